// file: hdl/adcr_map.svh
// Purpose : Offsets, field positions and reset values of the decoder control registers.
// Assumes : 7-bit register addresses, 8-bit registers.
// Notes   : Definitions only; included by bare name.
`ifndef ADCR_MAP_SVH
`define ADCR_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADCR_OFS_CHIP_ID       7'h01
`define ADCR_OFS_CLK_CTRL      7'h05
`define ADCR_OFS_PLL_MULT      7'h06
`define ADCR_OFS_PLL_DIV       7'h07
`define ADCR_OFS_REQUEST_LINE_POLARITY       7'h0C
`define ADCR_OFS_EDGE_SEL      7'h0D
`define ADCR_OFS_LAST_ERR      7'h0F
`define ADCR_OFS_RESTART       7'h10
`define ADCR_OFS_PLAY          7'h13
`define ADCR_OFS_MUTE          7'h14
`define ADCR_OFS_ANC_CMD       7'h16
`define ADCR_OFS_PIN_FUNC      7'h18
`define ADCR_OFS_LOCK          7'h40
`define ADCR_OFS_ANC_BITS_L    7'h41
`define ADCR_OFS_ANC_BITS_H    7'h42
`define ADCR_OFS_HEAD_H        7'h43
`define ADCR_OFS_HEAD_M        7'h44
`define ADCR_OFS_HEAD_L        7'h45
`define ADCR_OFS_ANC_FIRST     7'h59
`define ADCR_OFS_ANC_LAST      7'h5D

// ----------------------------------------------------------------
// Reset values (hardware and software reset alike)
// ----------------------------------------------------------------
`define ADCR_RST_CLK_CTRL      8'h21
`define ADCR_RST_PLL_MULT      8'h0C
`define ADCR_RST_PLL_DIV       8'h00
`define ADCR_RST_REQUEST_LINE_POLARITY       8'h01
`define ADCR_RST_EDGE_SEL      8'h04
`define ADCR_RST_PLAY          8'h01
`define ADCR_RST_MUTE          8'h00
`define ADCR_RST_ANC_CMD       8'h00
`define ADCR_RST_PIN_FUNC      8'h00
`define ADCR_RST_ZERO          8'h00

// ----------------------------------------------------------------
// Field positions and sizes
// ----------------------------------------------------------------
`define ADCR_BIT_INVERT        2
`define ADCR_BIT_PLAY          0
`define ADCR_BIT_MUTE          0
`define ADCR_ANC_BYTES         5

`endif

// file: hdl/adcr_pkg.sv
// Purpose : Types shared by the decoder control register block.
// Assumes : Offsets and reset values live in adcr_map.svh.
// Notes   : Packed structs carry grouped signals across ports.
package adcr_pkg;

	// ----------------------------------------------------------------
	// Register access request from the control-bus engine
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;     // One-cycle write strobe
		logic       rd;     // One-cycle read strobe
		logic [6:0] addr;   // Register sub-address
		logic [7:0] wdata;  // Write byte
	} adcr_reg_req_s;

	// Clock generator control byte, bit 7 first
	typedef struct packed {
		logic sharedPinEnable;
		logic crystalOutPadDisable;
		logic outputClockPadEnable;
		logic systemToOutputClock;
		logic vcoDisable;
		logic crystalToCoreDivider;
		logic crystalToOutclkDivider;
		logic fractionUpdate;
	} adcr_clk_ctrl_s;

	// Per-frame report from the decoding datapath
	typedef struct packed {
		logic        sync;     // Pulse: locked onto a new frame
		logic [20:0] header;   // Captured header bits 20..0
		logic        good;     // Pulse: frame decoded correctly
		logic [15:0] ancBits;  // Ancillary bits in that frame
	} adcr_frame_s;

	// Error codes
	typedef enum logic [7:0] {
		ADCR_ERR_NONE   = 8'h00,
		ADCR_ERR_CRC    = 8'h01,
		ADCR_ERR_NODATA = 8'h02
	} adcr_err_e;

	// Ancillary buffer fill sequencer
	typedef enum logic [2:0] {
		ADCR_FILL_IDLE = 3'b001,
		ADCR_FILL_RUN  = 3'b010,
		ADCR_FILL_DONE = 3'b100
	} adcr_fill_e;

endpackage : adcr_pkg

// file: hdl/adcr_anc_mem.sv
// Purpose : Small byte buffer holding the ancillary data for host readout.
// Assumes : One write and one read port on the same clock.
// Notes   : Read data is registered; one cycle of read latency.
`timescale 1ns/10ps
module adcr_anc_mem #(
	parameter int DEPTH = 5,
	parameter int WIDTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             mclk,
	input  wire logic             rstN,
	input  wire logic             clr,
	input  wire logic             wrEn,
	input  wire logic [AW-1:0]    wrAddr,
	input  wire logic [WIDTH-1:0] wrData,
	input  wire logic [AW-1:0]    rdAddr,
	output logic      [WIDTH-1:0] rdData_q
);

	// ----------------------------------------------------------------
	// Storage words
	// ----------------------------------------------------------------
	logic [WIDTH-1:0] word_q [DEPTH];  // One flop row per byte

	// Each row clears on either reset, so readout is zero before any fill
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_word
			always_ff @(posedge mclk or negedge rstN)
			begin
				if (!rstN)
					word_q[gi] <= '0;
				else if (clr)
					word_q[gi] <= '0;
				else if (wrEn && (wrAddr == AW'(gi)))
					word_q[gi] <= wrData;
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Registered read; out-of-range index reads zero
	// ----------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			rdData_q <= '0;
		else if (rdAddr < AW'(DEPTH))
			rdData_q <= word_q[rdAddr];
		else
			rdData_q <= '0;
	end

endmodule : adcr_anc_mem

// file: hdl/adcr_control_regs.sv
// Purpose : Control and status registers of the compressed-audio decoder.
// Assumes : Control-bus engine presents byte requests synchronous to mclk.
// Notes   : Reads answer two cycles after the strobe; all outputs registered.
`timescale 1ns/10ps
`include "adcr_map.svh"

// Summary of operation
// - Fixed read-only chip identification byte
// - Clock control resets 0x21, bit0 fraction transfer
// - Bit1 feeds output divider from crystal
// - Bit2 feeds core divider from crystal
// - Bit3 disables VCO, zero after reset
// - Bit4 output clock at system rate
// - Bit5 enables output clock pad, resets one
// - Bit6 disables crystal output pad
// - Bit7 enables shared pin, left cleared
// - PLL multiplier 0x0C, divider 0x00, read/write
// - Request polarity: 0x01 high, bit2 low
// - Edge select 0x00 rising, 0x04 falling
// - Error byte holds latest error code
// - Restart write soft-resets, clears command, idles
// - Play resets one, acts in decode mode
// - Mute silences output, clock keeps running
// - Nonzero load command refills five ancillary bytes
// - Pin function bit2: clock or request
// - Buffered clock follows crystal input frequency up to half of mclk
// - Lock state: search, confirm, locked
// - Two bytes form ancillary bit count
// - Header bytes refresh on each new sync
module adcr_control_regs #(
	parameter logic [7:0] CHIP_ID = 8'h5A  // Arbitrary identification value
) (
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	input  wire adcr_pkg::adcr_reg_req_s  regReq,
	output logic      [7:0]               regRdData_q,
	output logic                          regRdValid_q,
	input  wire adcr_pkg::adcr_frame_s    frameIn,
	input  wire logic                     errEvent,
	input  wire adcr_pkg::adcr_err_e      errCode,
	input  wire logic [1:0]               lockState,
	input  wire logic                     decodeMode,
	input  wire logic                     crystalIn,
	input  wire logic                     dataWanted,
	input  wire logic [39:0]              ancSource,
	output adcr_pkg::adcr_clk_ctrl_s      clkCtrl_q,
	output logic      [7:0]               pllMult_q,
	output logic      [7:0]               pllDiv_q,
	output logic                          reqActiveLow_q,
	output logic                          sampleOnFalling_q,
	output logic                          softReset_q,
	output logic                          playActive_q,
	output logic                          muteActive_q,
	output logic                          ancFillBusy_q,
	output logic                          sharedPin_q,
	output logic                          sharedPinOe_q
);
	import adcr_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstMeta_q;  // First release stage
	logic rstN;       // Released reset used everywhere else

	// Assert asynchronously, release after two edges
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstMeta_q <= 1'b0;
			rstN      <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstN      <= rstMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Decoding used by the write path; the read path decodes in its own case
	function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
		hit = (a == ofs);
	endfunction : hit

	// Only byte writes to writable offsets land; writes elsewhere are dropped
	wire wrClk     = regReq.wr && hit(regReq.addr, `ADCR_OFS_CLK_CTRL);
	wire wrMult    = regReq.wr && hit(regReq.addr, `ADCR_OFS_PLL_MULT);
	wire wrDiv     = regReq.wr && hit(regReq.addr, `ADCR_OFS_PLL_DIV);
	wire wrReqPol  = regReq.wr && hit(regReq.addr, `ADCR_OFS_REQUEST_LINE_POLARITY);
	wire wrEdge    = regReq.wr && hit(regReq.addr, `ADCR_OFS_EDGE_SEL);
	wire wrRestart = regReq.wr && hit(regReq.addr, `ADCR_OFS_RESTART);
	wire wrPlay    = regReq.wr && hit(regReq.addr, `ADCR_OFS_PLAY);
	wire wrMute    = regReq.wr && hit(regReq.addr, `ADCR_OFS_MUTE);
	wire wrAncCmd  = regReq.wr && hit(regReq.addr, `ADCR_OFS_ANC_CMD);
	wire wrPinFunc = regReq.wr && hit(regReq.addr, `ADCR_OFS_PIN_FUNC);

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	logic [7:0] reqPol_q;    // Request line polarity byte
	logic [7:0] edgeSel_q;   // Input clock edge select byte
	logic [7:0] play_q;      // Play command byte
	logic [7:0] mute_q;      // Mute command byte
	logic [7:0] ancCmd_q;    // Ancillary load command byte
	logic [7:0] pinFunc_q;   // Shared pin function byte
	logic       fillStart;   // Sequencer leaves idle this cycle

	// Host writes; restart puts every byte back to its reset value
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			clkCtrl_q <= `ADCR_RST_CLK_CTRL;
			pllMult_q <= `ADCR_RST_PLL_MULT;
			pllDiv_q  <= `ADCR_RST_PLL_DIV;
			reqPol_q  <= `ADCR_RST_REQUEST_LINE_POLARITY;
			edgeSel_q <= `ADCR_RST_EDGE_SEL;
			play_q    <= `ADCR_RST_PLAY;
			mute_q    <= `ADCR_RST_MUTE;
			ancCmd_q  <= `ADCR_RST_ANC_CMD;
			pinFunc_q <= `ADCR_RST_PIN_FUNC;
		end
		else if (wrRestart)
		begin
			// Soft reset: command byte cleared with everything else
			clkCtrl_q <= `ADCR_RST_CLK_CTRL;
			pllMult_q <= `ADCR_RST_PLL_MULT;
			pllDiv_q  <= `ADCR_RST_PLL_DIV;
			reqPol_q  <= `ADCR_RST_REQUEST_LINE_POLARITY;
			edgeSel_q <= `ADCR_RST_EDGE_SEL;
			play_q    <= `ADCR_RST_PLAY;
			mute_q    <= `ADCR_RST_MUTE;
			ancCmd_q  <= `ADCR_RST_ANC_CMD;
			pinFunc_q <= `ADCR_RST_PIN_FUNC;
		end
		else
		begin
			if (wrClk)
				clkCtrl_q <= regReq.wdata;
			if (wrMult)
				pllMult_q <= regReq.wdata;
			if (wrDiv)
				pllDiv_q  <= regReq.wdata;
			if (wrReqPol)
				reqPol_q  <= regReq.wdata;
			if (wrEdge)
				edgeSel_q <= regReq.wdata;
			if (wrPlay)
				play_q    <= regReq.wdata;
			if (wrMute)
				mute_q    <= regReq.wdata;
			if (wrPinFunc)
				pinFunc_q <= regReq.wdata;
			// A host write in the start cycle wins over the self-clear
			if (wrAncCmd)
				ancCmd_q  <= regReq.wdata;
			else if (fillStart)
				ancCmd_q  <= `ADCR_RST_ANC_CMD;
		end
	end

	// ----------------------------------------------------------------
	// Status captured from the datapath
	// ----------------------------------------------------------------
	logic [7:0]  lastErr_q;   // Most recent error code
	logic [15:0] ancBits_q;   // Ancillary bits of last good frame
	logic [20:0] header_q;    // Last captured frame header

	// Restart clears status, but an event in that same cycle is kept
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			lastErr_q <= ADCR_ERR_NONE;
			ancBits_q <= '0;
			header_q  <= '0;
		end
		else
		begin
			if (errEvent)
				lastErr_q <= errCode;
			else if (wrRestart)
				lastErr_q <= ADCR_ERR_NONE;
			if (frameIn.good)
				ancBits_q <= frameIn.ancBits;
			else if (wrRestart)
				ancBits_q <= '0;
			if (frameIn.sync)
				header_q  <= frameIn.header;
			else if (wrRestart)
				header_q  <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Ancillary buffer fill sequencer
	// ----------------------------------------------------------------
	adcr_fill_e fillState_q;   // Sequencer state
	adcr_fill_e fillState_d;   // Next state
	logic [2:0] fillIdx_q;     // Byte being written
	wire        fillLast = (fillIdx_q == 3'(`ADCR_ANC_BYTES - 1));
	wire        fillWr   = (fillState_q == ADCR_FILL_RUN);

	assign fillStart = (fillState_q == ADCR_FILL_IDLE) && (ancCmd_q != 8'h00) && !wrRestart;

	// One byte per cycle; a command rewritten meanwhile queues another pass
	always_comb
	begin
		fillState_d = fillState_q;
		case (fillState_q)
			ADCR_FILL_IDLE: if (fillStart) fillState_d = ADCR_FILL_RUN;
			ADCR_FILL_RUN:  if (fillLast) fillState_d = ADCR_FILL_DONE;
			ADCR_FILL_DONE: fillState_d = ADCR_FILL_IDLE;
			default:        fillState_d = ADCR_FILL_IDLE;
		endcase
	end

	// State and byte index; restart abandons a fill in flight
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			fillState_q <= ADCR_FILL_IDLE;
			fillIdx_q   <= '0;
		end
		else if (wrRestart)
		begin
			fillState_q <= ADCR_FILL_IDLE;
			fillIdx_q   <= '0;
		end
		else
		begin
			fillState_q <= fillState_d;
			fillIdx_q   <= fillWr ? fillIdx_q + 3'h1 : 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// Ancillary byte buffer
	// ----------------------------------------------------------------
	wire [6:0] ancOfs   = regReq.addr - `ADCR_OFS_ANC_FIRST;
	wire [7:0] ancByte  = ancSource[{fillIdx_q, 3'h0} +: 8];
	logic [7:0] ancRd;   // Registered buffer read data

	adcr_anc_mem #(
		.DEPTH (`ADCR_ANC_BYTES),
		.WIDTH (8),
		.AW    (3)
	) u_anc_mem (
		.mclk     (mclk),
		.rstN     (rstN),
		.clr      (wrRestart),
		.wrEn     (fillWr),
		.wrAddr   (fillIdx_q),
		.wrData   (ancByte),
		.rdAddr   (ancOfs[2:0]),
		.rdData_q (ancRd)
	);

	// ----------------------------------------------------------------
	// Read path: stage one selects, stage two drives the bus
	// ----------------------------------------------------------------
	logic       rdStage_q;   // Read taken last cycle
	logic [6:0] rdAddr_q;    // Its address
	logic [7:0] rdMux;       // Selected byte

	// Unmapped and write-only offsets read as zero
	always_comb
	begin
		rdMux = 8'h00;
		case (rdAddr_q)
			`ADCR_OFS_CHIP_ID:    rdMux = CHIP_ID;
			`ADCR_OFS_CLK_CTRL:   rdMux = clkCtrl_q;
			`ADCR_OFS_PLL_MULT:   rdMux = pllMult_q;
			`ADCR_OFS_PLL_DIV:    rdMux = pllDiv_q;
			`ADCR_OFS_REQUEST_LINE_POLARITY:    rdMux = reqPol_q;
			`ADCR_OFS_EDGE_SEL:   rdMux = edgeSel_q;
			`ADCR_OFS_LAST_ERR:   rdMux = lastErr_q;
			`ADCR_OFS_PLAY:       rdMux = play_q;
			`ADCR_OFS_MUTE:       rdMux = mute_q;
			`ADCR_OFS_ANC_CMD:    rdMux = ancCmd_q;
			`ADCR_OFS_PIN_FUNC:   rdMux = pinFunc_q;
			`ADCR_OFS_LOCK:       rdMux = {6'h00, lockState};
			`ADCR_OFS_ANC_BITS_L: rdMux = ancBits_q[7:0];
			`ADCR_OFS_ANC_BITS_H: rdMux = ancBits_q[15:8];
			`ADCR_OFS_HEAD_H:     rdMux = {3'h0, header_q[20:16]};
			`ADCR_OFS_HEAD_M:     rdMux = header_q[15:8];
			`ADCR_OFS_HEAD_L:     rdMux = header_q[7:0];
			default:
				if (rdAddr_q >= `ADCR_OFS_ANC_FIRST && rdAddr_q <= `ADCR_OFS_ANC_LAST)
					rdMux = ancRd;
		endcase
	end

	// Host reads whole bytes only, so no partial-lane handling here
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			rdStage_q    <= 1'b0;
			rdAddr_q     <= '0;
			regRdValid_q <= 1'b0;
			regRdData_q  <= 8'h00;
		end
		else
		begin
			rdStage_q    <= regReq.rd;
			rdAddr_q     <= regReq.addr;
			regRdValid_q <= rdStage_q;
			regRdData_q  <= rdStage_q ? rdMux : 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Control outputs to the clock, input and output stages
	// ----------------------------------------------------------------
	wire pinIsRequest = pinFunc_q[`ADCR_BIT_INVERT];
	wire reqLow       = reqPol_q[`ADCR_BIT_INVERT];

	// Crystal input is resampled, so the buffered clock keeps its rate
	// but lags by a cycle and is limited to half of mclk
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			reqActiveLow_q    <= 1'b0;
			sampleOnFalling_q <= 1'b1;
			softReset_q       <= 1'b0;
			playActive_q      <= 1'b0;
			muteActive_q      <= 1'b0;
			ancFillBusy_q     <= 1'b0;
			sharedPin_q       <= 1'b0;
			sharedPinOe_q     <= 1'b0;
		end
		else
		begin
			reqActiveLow_q    <= reqLow;
			sampleOnFalling_q <= edgeSel_q[`ADCR_BIT_INVERT];
			softReset_q       <= wrRestart;
			playActive_q      <= play_q[`ADCR_BIT_PLAY] && decodeMode;
			muteActive_q      <= mute_q[`ADCR_BIT_MUTE];
			ancFillBusy_q     <= fillState_d == ADCR_FILL_RUN;
			sharedPin_q       <= pinIsRequest ? (dataWanted ^ reqLow) : crystalIn;
			sharedPinOe_q     <= clkCtrl_q.sharedPinEnable;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstN);

	sequence s_rd(logic [6:0] a);
		regReq.rd && regReq.addr == a;
	endsequence
	sequence s_answer;
		##2 regRdValid_q;
	endsequence

	chk_id_read_fixed: assert property (s_rd(`ADCR_OFS_CHIP_ID) |-> s_answer ##0 regRdData_q == CHIP_ID)
		else $error("identification byte wrong");
	chk_clk_ctrl_write: assert property (wrClk && !wrRestart |=> clkCtrl_q == $past(regReq.wdata))
		else $error("clock control write lost");
	chk_req_polarity: assert property (##1 reqActiveLow_q == $past(reqPol_q[2]))
		else $error("request polarity not followed");
	chk_edge_select: assert property (wrEdge && !wrRestart |-> ##2 sampleOnFalling_q == $past(regReq.wdata[2], 2))
		else $error("edge select not followed");
	chk_error_capture: assert property (errEvent |=> lastErr_q == $past(errCode))
		else $error("error code not captured");
	chk_restart_pulse: assert property (wrRestart |=> softReset_q && ancCmd_q == 8'h00 && play_q == 8'h01)
		else $error("soft reset incomplete");
	chk_play_gate: assert property (playActive_q |-> $past(decodeMode))
		else $error("play active outside decode");
	sequence s_fill_req;
		wrAncCmd && regReq.wdata != 8'h00 && !wrRestart && !ancFillBusy_q && fillState_q == ADCR_FILL_IDLE;
	endsequence
	chk_anc_refill: assert property (s_fill_req |-> ##2 ancFillBusy_q [*5] ##1 !ancFillBusy_q)
		else $error("ancillary refill not five bytes");
	chk_header_capture: assert property (frameIn.sync |=> header_q == $past(frameIn.header))
		else $error("header not captured");
	chk_head_high_pad: assert property (s_rd(`ADCR_OFS_HEAD_H) |-> s_answer ##0 regRdData_q[7:5] == 3'h0)
		else $error("header high pad bits set");
	chk_lock_read: assert property (s_rd(`ADCR_OFS_LOCK) |-> s_answer ##0 regRdData_q == {6'h00, $past(lockState, 1)})
		else $error("lock state read wrong");

endmodule : adcr_control_regs

// file: tb/adcr_host_model.sv
// Purpose : Host side of the register bus: single-byte writes and reads.
// Assumes : Requests change on falling mclk; read answer comes a few cycles later.
// Notes   : Byte access to documented offsets only.
`timescale 1ns/10ps
module adcr_host_model (
	input  wire logic               mclk,
	output adcr_pkg::adcr_reg_req_s regReq,
	input  wire logic [7:0]         rdData,
	input  wire logic               rdValid
);
	import adcr_pkg::*;
	// ------------------------------------------------------------
	// Bus tasks
	// ------------------------------------------------------------
	initial regReq = '0;
	// One-cycle strobe; the next call waits a falling edge, so strobes never merge
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge mclk);
		regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge mclk);
		regReq.wr = 1'b0;
	endtask : wr
	// Valid stands one cycle, so it is looked at mid-cycle; ok stays low on timeout
	task automatic rd(input logic [6:0] a, output logic [7:0] d, output bit ok);
		@(negedge mclk);
		regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge mclk);
		regReq.rd = 1'b0;
		ok = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (rdValid === 1'b1)
			begin
				d = rdData;
				ok = 1'b1;
			end
			else
				@(negedge mclk);
		end
	endtask : rd
endmodule : adcr_host_model

// file: tb/tb.sv
// Purpose : Self-checking bench for the decoder control registers.
// Assumes : Inputs change on falling mclk; host model drives the register bus.
// Notes   : Identification parameter set to an arbitrary value.
`timescale 1ns/10ps
module tb;
	import adcr_pkg::*;
	localparam logic [7:0] ID = 8'h3C; // Arbitrary value
	logic mclk, rst_n, errEvent, decodeMode, crystalIn, dataWanted, rdValid;
	logic reqLow, sampleFall, softRst, play, mute, busy, pin, pinOe;
	logic [1:0] lockState;
	logic [39:0] ancSource;
	logic [7:0] rdData, pllMult, pllDiv;
	adcr_err_e errCode;
	adcr_frame_s frameIn;
	adcr_reg_req_s regReq;
	adcr_clk_ctrl_s clkCtrl;
	int mismatches = 0, n_tests = 0;
	// ------------------------------------------------------------
	// Clock, parts
	// ------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	adcr_host_model HOST (.mclk(mclk), .regReq(regReq), .rdData(rdData), .rdValid(rdValid));
	adcr_control_regs #(.CHIP_ID(ID)) DUT (.mclk(mclk), .rst_n(rst_n), .regReq(regReq),
		.regRdData_q(rdData), .regRdValid_q(rdValid), .frameIn(frameIn), .errEvent(errEvent),
		.errCode(errCode), .lockState(lockState), .decodeMode(decodeMode), .crystalIn(crystalIn),
		.dataWanted(dataWanted), .ancSource(ancSource), .clkCtrl_q(clkCtrl), .pllMult_q(pllMult),
		.pllDiv_q(pllDiv), .reqActiveLow_q(reqLow), .sampleOnFalling_q(sampleFall),
		.softReset_q(softRst), .playActive_q(play), .muteActive_q(mute),
		.ancFillBusy_q(busy), .sharedPin_q(pin), .sharedPinOe_q(pinOe));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : ck
	// A read that never answers ends the run
	task automatic rdck(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] d;
		bit ok;
		HOST.rd(a, d, ok);
		if (!ok)
		begin
			mismatches++;
			$display("CHECK FAILED read valid at %h expected 1 seen 0", a);
			wrap_up();
		end
		else
			ck($sformatf("reg %h", a), e, d);
	endtask : rdck
	task automatic waitn(input int n);
		repeat (n) @(negedge mclk);
	endtask : waitn
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		ck("clk ctrl", 8'h21, clkCtrl);
		rdck(7'h01, ID);
		rdck(7'h05, 8'h21);
		rdck(7'h06, 8'h0C);
		rdck(7'h07, 8'h00);
		rdck(7'h0C, 8'h01);
		rdck(7'h0D, 8'h04);
		ck("fall", 8'h01, {7'h00, sampleFall});
		rdck(7'h10, 8'h00);
		rdck(7'h13, 8'h01);
		rdck(7'h14, 8'h00);
	endtask : t_reset
	task automatic t_clk;
		HOST.wr(7'h05, 8'hDE);
		HOST.wr(7'h06, 8'h5A);
		HOST.wr(7'h07, 8'hA5);
		rdck(7'h05, 8'hDE);
		ck("clk out", 8'hDE, clkCtrl);
		ck("pin oe", 8'h01, {7'h00, pinOe});
		rdck(7'h01, ID);
		rdck(7'h06, 8'h5A);
		rdck(7'h07, 8'hA5);
		ck("mult", 8'h5A, pllMult);
		ck("div", 8'hA5, pllDiv);
	endtask : t_clk
	task automatic t_pins;
		dataWanted = 1'b1;
		HOST.wr(7'h0C, 8'h05);
		HOST.wr(7'h18, 8'h04);
		rdck(7'h0C, 8'h05);
		ck("req low", 8'h01, {7'h00, reqLow});
		ck("pin req", 8'h00, {7'h00, pin});
		HOST.wr(7'h0C, 8'h01);
		HOST.wr(7'h0D, 8'h00);
		rdck(7'h0D, 8'h00);
		ck("pin req hi", 8'h01, {7'h00, pin});
		ck("fall", 8'h00, {7'h00, sampleFall});
		HOST.wr(7'h18, 8'h00);
		crystalIn = 1'b1;
		waitn(3);
		ck("pin clk1", 8'h01, {7'h00, pin});
		crystalIn = 1'b0;
		waitn(3);
		ck("pin clk0", 8'h00, {7'h00, pin});
	endtask : t_pins
	task automatic t_status;
		for (int i = 1; i < 3; i++)
		begin
			@(negedge mclk);
			errCode = adcr_err_e'(i);
			errEvent = 1'b1;
			@(negedge mclk);
			errEvent = 1'b0;
			rdck(7'h0F, 8'(i));
		end
		for (int i = 0; i < 3; i++)
		begin
			lockState = 2'(i);
			rdck(7'h40, 8'(i));
		end
		@(negedge mclk);
		frameIn = '{sync: 1'b1, header: 21'h1ABCDE, good: 1'b1, ancBits: 16'h1234};
		@(negedge mclk);
		frameIn = '0;
		rdck(7'h41, 8'h34);
		rdck(7'h42, 8'h12);
		rdck(7'h43, 8'h1A);
		rdck(7'h44, 8'hBC);
		rdck(7'h45, 8'hDE);
	endtask : t_status
	task automatic t_play;
		decodeMode = 1'b0;
		HOST.wr(7'h14, 8'h01);
		rdck(7'h14, 8'h01);
		ck("play idle", 8'h00, {7'h00, play});
		ck("mute", 8'h01, {7'h00, mute});
		decodeMode = 1'b1;
		waitn(2);
		ck("play dec", 8'h01, {7'h00, play});
	endtask : t_play
	task automatic t_anc;
		int k;
		ancSource = 40'h5544332211;
		HOST.wr(7'h16, 8'h01);
		for (int i = 0; i < 8 && busy !== 1'b1; i++)
			@(negedge mclk);
		for (k = 0; k < 9 && busy === 1'b1; k++)
			@(negedge mclk);
		ck("fill len", 8'h05, 8'(k));
		for (int i = 0; i < 5; i++)
			rdck(7'h59 + 7'(i), 8'h11 * 8'(i + 1));
	endtask : t_anc
	task automatic t_soft;
		HOST.wr(7'h10, 8'hA5);
		ck("pulse", 8'h01, {7'h00, softRst});
		@(negedge mclk);
		ck("pulse end", 8'h00, {7'h00, softRst});
		@(negedge mclk);
		ck("pulse once", 8'h00, {7'h00, softRst});
		rdck(7'h0F, 8'h00);
		rdck(7'h05, 8'h21);
		rdck(7'h16, 8'h00);
		rdck(7'h14, 8'h00);
		rdck(7'h43, 8'h00);
	endtask : t_soft
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{rst_n, errEvent, decodeMode, crystalIn, dataWanted, lockState, ancSource} = '0;
		errCode = ADCR_ERR_NONE;
		frameIn = '0;
		waitn(10);
		rst_n = 1'b1;
		waitn(3);
		t_reset();
		t_clk();
		t_pins();
		t_status();
		t_play();
		t_anc();
		t_soft();
		wrap_up();
	end
endmodule : tb
